// *** dbs_pkg.sv ***
// package of constants and types for the brake, stall and torque-off supervisor
package dbs_pkg;
	// clock and time base
	localparam int unsigned CLK_HZ = 200_000_000;
	localparam int unsigned TICK_US = 1000;
	localparam int unsigned TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
	localparam int unsigned PRE_W = 18;
	// release sequence figures
	localparam int unsigned REL_WAIT_MS = 20;
	localparam logic [15:0] REL_WAIT_TICKS = 16'(REL_WAIT_MS);
	localparam logic [3:0] BACK_STEPS = 4'h4;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STAT = 8'h04;
	localparam logic [7:0] OFS_BRK_DLY = 8'h08;
	localparam logic [7:0] OFS_STALL_PCT = 8'h0C;
	localparam logic [7:0] OFS_STALL_MS = 8'h10;
	localparam logic [7:0] OFS_TARGET = 8'h14;
	localparam logic [7:0] OFS_IRQ_ST = 8'h18;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h1C;
	// control word bits
	localparam int CTL_FWD = 0;
	localparam int CTL_REV = 1;
	localparam int CTL_RELEASE = 4;
	// status word bits
	localparam int STS_BRAKE_REL = 2;
	localparam int STS_MOVING = 6;
	localparam int STS_STO = 8;
	localparam int STS_DIAG = 9;
	localparam int STS_POS_ERR = 10;
	// interrupt bits
	localparam int IRQ_DONE = 0;
	localparam int IRQ_STALL = 1;
	localparam int IRQ_STO = 2;
	localparam int IRQ_DIAG = 3;
	// reset values and the full-scale percentage
	localparam logic [15:0] RST_BRK_DLY_MS = 16'h03E8;
	localparam logic [7:0] RST_STALL_PCT = 8'h1E;
	localparam logic [15:0] RST_STALL_MS = 16'h00C8;
	localparam logic [15:0] RST_TARGET = 16'h0000;
	localparam logic [7:0] PCT_FULL = 8'h64;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_REL_WAIT,
		ST_REL_BACK,
		ST_RUN,
		ST_STO
	} dbs_state_t;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [7:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} dbs_wb_req_t;

	typedef struct packed {
		logic ack;
		logic [31:0] dat;
	} dbs_wb_rsp_t;

	typedef struct packed {
		logic move_fwd;
		logic move_rev;
		logic back_step;
		logic torque_en;
		logic brake_release;
	} dbs_drive_t;
endpackage : dbs_pkg

// *** dbs_ctrl.sv ***
// brake sequencing, stall abort and safe torque off supervisor with wishbone registers
`timescale 1ns/10ps
// Summary of operation
// - a run command with the brake fitted and closed waits briefly, then steps a few increments backwards.
// - after each run not ended by torque-off the brake closes once the configurable delay, one second by default, has passed.
// - a run starting before the close delay expires keeps the brake released and skips the release steps.
// - a run aborts when speed stays below the stall fraction of target speed longer than the stall time.
// - the stall fraction resets to thirty percent and the stall time to two hundred milliseconds.
// - a manual run starts from control bit 0 or 1 together with release bit 4 and moves that way.
// - status bit 6 is set while the drive moves and cleared once it stops.
// - a run ended by stall clears the moving bit and sets status bit 10.
// - while the torque-off input is active all motor torque is removed at once.
// - torque-off is left on its own once the input drops, unless a diagnostic fault is latched.
// - a diagnostic failure latches torque-off until the next power-on reset.
// - the latched diagnostic state shows in status bit 9.
module dbs_ctrl #(
	parameter int unsigned TICK_CYCLES = dbs_pkg::TICK_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire dbs_pkg::dbs_wb_req_t wb_req,
	output dbs_pkg::dbs_wb_rsp_t wb_rsp,
	input wire logic [15:0] measured_speed,
	input wire logic run_end,
	input wire logic diag_fail,
	input wire logic safe_torque_off_input,
	input wire logic brake_fitted,
	output dbs_pkg::dbs_drive_t drive,
	output logic irq
);
	import dbs_pkg::*;

	typedef struct packed {
		dbs_state_t st;
		logic [15:0] ctrl;
		logic [15:0] brk_dly;
		logic [7:0] stall_pct;
		logic [15:0] stall_ms;
		logic [15:0] target;
		logic [3:0] irq_st;
		logic [3:0] irq_mask;
		logic [PRE_W-1:0] pre;
		logic [15:0] tmr;
		logic [15:0] brk_tmr;
		logic [3:0] steps;
		logic dir_rev;
		logic rearm;
		logic moving;
		logic pos_err;
		logic diag_lat;
		logic sto_s1;
		logic sto_s2;
		logic fit_s1;
		logic fit_s2;
		dbs_drive_t drv;
		dbs_wb_rsp_t rsp;
		logic irq;
	} dbs_regs_t;

	dbs_regs_t state_reg;
	dbs_regs_t state_next;

	// speed below limit: speed*100 < target*pct, widened so neither side wraps
	function automatic logic below_limit(input logic [15:0] spd, input logic [15:0] tgt, input logic [7:0] pct);
		logic [31:0] lhs;
		logic [31:0] rhs;
		lhs = 32'(spd) * 32'(PCT_FULL);
		rhs = 32'(tgt) * 32'(pct);
		return lhs < rhs;
	endfunction : below_limit

	// last tick of a span of lim ticks; a zero span ends at once rather than wrapping
	function automatic logic at_limit(input logic [15:0] cnt, input logic [15:0] lim);
		return (lim == 16'h0000) || (cnt >= lim - 16'h0001);
	endfunction : at_limit

	// byte-lane merge for a sixteen bit field in the low half
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] sel);
		logic [15:0] res;
		res = old;
		if (sel[0]) begin
			res[7:0] = wd[7:0];
		end
		if (sel[1]) begin
			res[15:8] = wd[15:8];
		end
		return res;
	endfunction : merge16

	logic [31:0] status_word;
	logic tick;
	logic run_req;
	logic run_dir_rev;
	logic bus_go;
	logic wr;
	logic [3:0] irq_set;
	logic [3:0] irq_clr;

	always_comb begin
		status_word = 32'h0000_0000;
		status_word[STS_BRAKE_REL] = state_reg.drv.brake_release;
		status_word[STS_MOVING] = state_reg.moving;
		status_word[STS_STO] = (state_reg.st == ST_STO);
		status_word[STS_DIAG] = state_reg.diag_lat;
		status_word[STS_POS_ERR] = state_reg.pos_err;
	end

	// free-running prescaler: the first tick of any wait may come up to one tick early
	assign tick = (state_reg.pre == PRE_W'(TICK_CYCLES - 1));
	// both direction bits at once is not a valid request and is ignored
	assign run_req = state_reg.ctrl[CTL_RELEASE] & (state_reg.ctrl[CTL_FWD] ^ state_reg.ctrl[CTL_REV]);
	assign run_dir_rev = state_reg.ctrl[CTL_REV];
	assign bus_go = wb_req.cyc & wb_req.stb & ~state_reg.rsp.ack;
	assign wr = bus_go & wb_req.we;

	always_comb begin
		state_next = state_reg;
		irq_set = 4'h0;
		irq_clr = 4'h0;
		// torque-off and brake-fitted pins pass two flops; only the second stage is read
		state_next.sto_s1 = safe_torque_off_input;
		state_next.sto_s2 = state_reg.sto_s1;
		state_next.fit_s1 = brake_fitted;
		state_next.fit_s2 = state_reg.fit_s1;
		state_next.pre = tick ? '0 : state_reg.pre + 1'b1;
		state_next.drv.back_step = 1'b0;

		// diagnostic latch is only cleared by reset
		if (diag_fail && !state_reg.diag_lat) begin
			state_next.diag_lat = 1'b1;
			irq_set[IRQ_DIAG] = 1'b1;
		end
		// a dropped command re-arms the next run
		if (!run_req) begin
			state_next.rearm = 1'b0;
		end

		// brake close delay counts only while idle with the brake open
		if (state_reg.st == ST_IDLE && state_reg.drv.brake_release && tick) begin
			if (at_limit(state_reg.brk_tmr, state_reg.brk_dly)) begin
				state_next.drv.brake_release = 1'b0;
				state_next.brk_tmr = 16'h0000;
			end else begin
				state_next.brk_tmr = state_reg.brk_tmr + 16'h0001;
			end
		end

		// run sequencer; the torque-off block below overrides it
		case (state_reg.st)
			ST_IDLE: begin
				state_next.moving = 1'b0;
				if (run_req && !state_reg.rearm) begin
					state_next.dir_rev = run_dir_rev;
					state_next.pos_err = 1'b0;
					state_next.tmr = 16'h0000;
					state_next.brk_tmr = 16'h0000;
					state_next.drv.torque_en = 1'b1;
					// a close falling due in this very cycle is cancelled, never applied mid-run
					state_next.drv.brake_release = state_reg.drv.brake_release;
					if (state_reg.fit_s2 && !state_reg.drv.brake_release) begin
						state_next.st = ST_REL_WAIT;
					end else begin
						state_next.st = ST_RUN;
						state_next.moving = 1'b1;
						state_next.drv.move_fwd = ~run_dir_rev;
						state_next.drv.move_rev = run_dir_rev;
					end
				end
			end
			ST_REL_WAIT: begin
				state_next.drv.brake_release = 1'b1;
				if (tick) begin
					if (at_limit(state_reg.tmr, REL_WAIT_TICKS)) begin
						state_next.tmr = 16'h0000;
						state_next.steps = BACK_STEPS;
						state_next.st = ST_REL_BACK;
					end else begin
						state_next.tmr = state_reg.tmr + 16'h0001;
					end
				end
			end
			ST_REL_BACK: begin
				state_next.moving = 1'b1;
				// one increment per tick, opposite to the requested way
				if (tick) begin
					if (state_reg.steps == 4'h0) begin
						state_next.st = ST_RUN;
						state_next.tmr = 16'h0000;
						state_next.drv.move_fwd = ~state_reg.dir_rev;
						state_next.drv.move_rev = state_reg.dir_rev;
					end else begin
						state_next.steps = state_reg.steps - 4'h1;
						state_next.drv.back_step = 1'b1;
						state_next.drv.move_fwd = state_reg.dir_rev;
						state_next.drv.move_rev = ~state_reg.dir_rev;
					end
				end
			end
			ST_RUN: begin
				state_next.moving = 1'b1;
				if (!run_req || run_end || run_dir_rev != state_reg.dir_rev) begin
					state_next.st = ST_IDLE;
					state_next.moving = 1'b0;
					// a finished run does not restart on the still-held command
					state_next.rearm = run_end;
					state_next.drv.move_fwd = 1'b0;
					state_next.drv.move_rev = 1'b0;
					state_next.brk_tmr = 16'h0000;
					irq_set[IRQ_DONE] = 1'b1;
				end else if (tick) begin
					if (below_limit(measured_speed, state_reg.target, state_reg.stall_pct)) begin
						if (state_reg.tmr >= state_reg.stall_ms) begin
							// held command must be dropped before the next run
							state_next.st = ST_IDLE;
							state_next.moving = 1'b0;
							state_next.pos_err = 1'b1;
							state_next.rearm = 1'b1;
							state_next.drv.move_fwd = 1'b0;
							state_next.drv.move_rev = 1'b0;
							state_next.brk_tmr = 16'h0000;
							irq_set[IRQ_STALL] = 1'b1;
						end else begin
							state_next.tmr = state_reg.tmr + 16'h0001;
						end
					end else begin
						state_next.tmr = 16'h0000;
					end
				end
			end
			ST_STO: begin
				// leave on its own; rearm stops a held command restarting at once
				if (!state_reg.sto_s2 && !state_reg.diag_lat && !diag_fail) begin
					state_next.st = ST_IDLE;
					state_next.rearm = 1'b1;
				end
			end
			default: begin
				state_next.st = ST_STO;
			end
		endcase

		// torque-off overrides every state, no ramp: category 0 stop
		if (state_reg.sto_s2 || state_reg.diag_lat || diag_fail) begin
			if (state_reg.st != ST_STO) begin
				irq_set[IRQ_STO] = 1'b1;
			end
			state_next.st = ST_STO;
			state_next.moving = 1'b0;
			state_next.drv.torque_en = 1'b0;
			state_next.drv.move_fwd = 1'b0;
			state_next.drv.move_rev = 1'b0;
			state_next.drv.back_step = 1'b0;
			state_next.drv.brake_release = 1'b0;
			state_next.brk_tmr = 16'h0000;
		end else if (state_reg.st == ST_STO) begin
			state_next.drv.torque_en = 1'b0;
		end

		// wishbone: ack one cycle after the request, dropped the next cycle
		state_next.rsp.ack = bus_go;
		state_next.rsp.dat = 32'h0000_0000;
		// read data stays zero outside ack
		if (bus_go && !wb_req.we) begin
			case (wb_req.adr)
				OFS_CTRL: state_next.rsp.dat = {16'h0000, state_reg.ctrl};
				OFS_STAT: state_next.rsp.dat = status_word;
				OFS_BRK_DLY: state_next.rsp.dat = {16'h0000, state_reg.brk_dly};
				OFS_STALL_PCT: state_next.rsp.dat = {24'h000000, state_reg.stall_pct};
				OFS_STALL_MS: state_next.rsp.dat = {16'h0000, state_reg.stall_ms};
				OFS_TARGET: state_next.rsp.dat = {16'h0000, state_reg.target};
				OFS_IRQ_ST: state_next.rsp.dat = {28'h0000000, state_reg.irq_st};
				OFS_IRQ_MASK: state_next.rsp.dat = {28'h0000000, state_reg.irq_mask};
				default: state_next.rsp.dat = 32'h0000_0000;
			endcase
		end
		// status is read-only; unmapped writes are dropped
		if (wr) begin
			case (wb_req.adr)
				OFS_CTRL: state_next.ctrl = merge16(state_reg.ctrl, wb_req.dat, wb_req.sel);
				OFS_BRK_DLY: state_next.brk_dly = merge16(state_reg.brk_dly, wb_req.dat, wb_req.sel);
				OFS_STALL_PCT: begin
					if (wb_req.sel[0]) begin
						state_next.stall_pct = wb_req.dat[7:0];
					end
				end
				OFS_STALL_MS: state_next.stall_ms = merge16(state_reg.stall_ms, wb_req.dat, wb_req.sel);
				OFS_TARGET: state_next.target = merge16(state_reg.target, wb_req.dat, wb_req.sel);
				OFS_IRQ_ST: begin
					if (wb_req.sel[0]) begin
						irq_clr = wb_req.dat[3:0];
					end
				end
				OFS_IRQ_MASK: begin
					if (wb_req.sel[0]) begin
						state_next.irq_mask = wb_req.dat[3:0];
					end
				end
				default: begin
				end
			endcase
		end
		// an event in the clearing cycle survives the clear
		state_next.irq_st = (state_reg.irq_st & ~irq_clr) | irq_set;
		state_next.irq = |(state_next.irq_st & state_next.irq_mask);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg <= '{
				st: ST_IDLE,
				ctrl: 16'h0000,
				brk_dly: RST_BRK_DLY_MS,
				stall_pct: RST_STALL_PCT,
				stall_ms: RST_STALL_MS,
				target: RST_TARGET,
				irq_st: 4'h0,
				irq_mask: 4'h0,
				pre: '0,
				tmr: 16'h0000,
				brk_tmr: 16'h0000,
				steps: 4'h0,
				dir_rev: 1'b0,
				rearm: 1'b0,
				moving: 1'b0,
				pos_err: 1'b0,
				diag_lat: 1'b0,
				sto_s1: 1'b0,
				sto_s2: 1'b0,
				fit_s1: 1'b0,
				fit_s2: 1'b0,
				drv: '0,
				rsp: '0,
				irq: 1'b0
			};
		end else if (ce) begin
			state_reg <= state_next;
		end
	end

	assign wb_rsp = state_reg.rsp;
	assign drive = state_reg.drv;
	assign irq = state_reg.irq;
endmodule : dbs_ctrl

// *** dbs_ctrl_sva.sv ***
// assertions on the ports of the brake, stall and torque-off supervisor
`timescale 1ns/10ps
module dbs_ctrl_chk import dbs_pkg::*; #(
	parameter int unsigned TICK_CYCLES = 10
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire dbs_pkg::dbs_wb_req_t wb_req,
	input wire dbs_pkg::dbs_wb_rsp_t wb_rsp,
	input wire logic [15:0] measured_speed,
	input wire logic run_end,
	input wire logic diag_fail,
	input wire logic safe_torque_off_input,
	input wire logic brake_fitted,
	input wire dbs_pkg::dbs_drive_t drive,
	input wire logic irq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	logic diag_seen_reg;
	// only a power-on reset may clear the diagnostic lock
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			diag_seen_reg <= 1'b0;
		end else if (diag_fail) begin
			diag_seen_reg <= 1'b1;
		end
	end
	chk_ack_reply: assert property (wb_req.cyc && wb_req.stb && !wb_rsp.ack && ce |=> wb_rsp.ack)
		else $error("no ack one cycle after request");
	chk_ack_single: assert property (wb_rsp.ack |=> !wb_rsp.ack)
		else $error("ack longer than one cycle");
	chk_rdata_idle: assert property (!wb_rsp.ack |-> wb_rsp.dat == 32'h0)
		else $error("read data outside ack");
	chk_dir_excl: assert property (!(drive.move_fwd && drive.move_rev))
		else $error("both directions driven");
	chk_move_released: assert property (brake_fitted && (drive.move_fwd || drive.move_rev) |->
		drive.brake_release && drive.torque_en) else $error("motion with brake closed");
	chk_step_pulse: assert property (drive.back_step |=> !drive.back_step)
		else $error("back step not a pulse");
	chk_step_brake: assert property (drive.back_step |-> drive.brake_release && drive.torque_en)
		else $error("back step without release");
	chk_torque_off: assert property (safe_torque_off_input [*4] |=>
		!drive.torque_en && !drive.move_fwd && !drive.move_rev) else $error("torque kept in torque-off");
	chk_diag_lock: assert property (diag_seen_reg && $past(diag_seen_reg) |->
		!drive.torque_en && !drive.move_fwd && !drive.move_rev) else $error("torque after diag fault");
	cov_steps: cover property (drive.back_step);
	cov_off: cover property ($rose(safe_torque_off_input));
	cov_irq: cover property ($rose(irq));
endmodule : dbs_ctrl_chk
bind dbs_ctrl dbs_ctrl_chk #(.TICK_CYCLES(TICK_CYCLES)) i_chk (.clk(clk), .rst(rst), .ce(ce), .wb_req(wb_req),
	.wb_rsp(wb_rsp), .measured_speed(measured_speed), .run_end(run_end), .diag_fail(diag_fail),
	.safe_torque_off_input(safe_torque_off_input), .brake_fitted(brake_fitted), .drive(drive), .irq(irq));

// *** dbs_host.sv ***
// wishbone master model of the fieldbus controller side
`timescale 1ns/10ps
module dbs_host (
	input wire logic clk,
	output dbs_pkg::dbs_wb_req_t wb_req,
	input wire dbs_pkg::dbs_wb_rsp_t wb_rsp
);
	import dbs_pkg::*;
	initial wb_req = '0;
	// called just after a rising edge; holds the request until ack is sampled
	task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd);
		wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: wd};
		// no cycle limit here: only the bench watchdog ends a wait
		do begin
			@(posedge clk);
		end while (wb_rsp.ack !== 1'b1);
		wb_req <= '0;
		@(posedge clk);
	endtask : xfer
endmodule : dbs_host

// *** tb.sv ***
// self-checking bench for the brake, stall and torque-off supervisor
`timescale 1ns/10ps
module tb;
	import dbs_pkg::*;
	logic clk, rst, ce, run_end, diag_fail, off_in, brake_fitted;
	logic [15:0] measured_speed;
	dbs_wb_req_t wb_req;
	dbs_wb_rsp_t wb_rsp;
	dbs_drive_t drive;
	logic irq;
	int fails, num_checks, st;
	logic [31:0] exp_q[$], msk_q[$];
	dbs_ctrl #(.TICK_CYCLES(10)) i_dbs_ctrl (.clk(clk), .rst(rst), .ce(ce), .wb_req(wb_req), .wb_rsp(wb_rsp),
		.measured_speed(measured_speed), .run_end(run_end), .diag_fail(diag_fail),
		.safe_torque_off_input(off_in), .brake_fitted(brake_fitted), .drive(drive), .irq(irq));
	dbs_host i_dbs_host (.clk(clk), .wb_req(wb_req), .wb_rsp(wb_rsp));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic results;
		if (fails == 0 && num_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : results
	task automatic cmp(input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("ERROR t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask : cmp
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		i_dbs_host.xfer(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		exp_q.push_back(e);
		msk_q.push_back(m);
		i_dbs_host.xfer(1'b0, a, 32'h0);
	endtask : rd
	// counts back steps until the wanted direction is driven
	task automatic run_to(input logic rev, output int s);
		int n;
		n = 0;
		s = 0;
		while ((rev ? drive.move_rev : drive.move_fwd) !== 1'b1 && n < 1000) begin
			@(posedge clk);
			s += int'(drive.back_step === 1'b1);
			n++;
		end
		cmp(32'h1, n < 1000);
	endtask : run_to
	always @(posedge clk) begin
		if (wb_rsp.ack === 1'b1 && wb_req.we === 1'b0 && exp_q.size() > 0) begin
			cmp(exp_q.pop_front(), wb_rsp.dat & msk_q.pop_front());
		end
	end
	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		results();
	end
	initial begin
		void'($urandom(15513));
		{rst, ce, run_end, diag_fail, off_in, brake_fitted} = 6'b110001;
		measured_speed = 16'h0000;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd(OFS_BRK_DLY, 32'h3E8, '1);
		rd(OFS_STALL_PCT, 32'h1E, '1);
		rd(OFS_STALL_MS, 32'hC8, '1);
		rd(8'h40, 32'h0, '1);
		wr(OFS_BRK_DLY, 32'h8);
		wr(OFS_TARGET, 32'h64);
		wr(OFS_STALL_MS, 32'h3);
		measured_speed <= 16'(31 + $urandom_range(500));
		wr(OFS_CTRL, 32'h11);
		run_to(1'b0, st);
		cmp(32'h4, st);
		rd(OFS_STAT, 32'h44, 32'h444);
		run_end <= 1'b1;
		@(posedge clk);
		run_end <= 1'b0;
		wr(OFS_CTRL, 32'h0);
		rd(OFS_STAT, 32'h4, 32'h44);
		repeat (40) @(posedge clk);
		wr(OFS_CTRL, 32'h12);
		run_to(1'b1, st);
		cmp(32'h0, st);
		run_end <= 1'b1;
		@(posedge clk);
		run_end <= 1'b0;
		wr(OFS_CTRL, 32'h0);
		// clock enable low freezes the close delay, so the brake must still be open
		ce <= 1'b0;
		repeat (40) @(posedge clk);
		ce <= 1'b1;
		repeat (60) @(posedge clk);
		cmp(32'h1, drive.brake_release);
		repeat (60) @(posedge clk);
		cmp(32'h0, drive.brake_release);
		// stall: speed held under the limit until the run aborts
		measured_speed <= 16'($urandom_range(29));
		wr(OFS_CTRL, 32'h11);
		run_to(1'b0, st);
		st = 0;
		while (drive.move_fwd !== 1'b0 && st < 70) begin
			@(posedge clk);
			st++;
		end
		cmp(32'h1, st < 70);
		cmp(32'h1, st >= 30);
		rd(OFS_STAT, 32'h400, 32'h440);
		wr(OFS_CTRL, 32'h0);
		wr(OFS_IRQ_MASK, 32'h2);
		cmp(32'h1, irq);
		wr(OFS_IRQ_MASK, 32'h0);
		cmp(32'h0, irq);
		wr(OFS_IRQ_MASK, 32'h2);
		wr(OFS_IRQ_ST, 32'h2);
		cmp(32'h0, irq);
		// torque-off during a run, then left on its own
		measured_speed <= 16'(31 + $urandom_range(500));
		wr(OFS_CTRL, 32'h11);
		run_to(1'b0, st);
		off_in <= 1'b1;
		repeat (5) @(posedge clk);
		cmp(32'h0, {drive.torque_en, drive.move_fwd});
		rd(OFS_STAT, 32'h100, 32'h140);
		wr(OFS_CTRL, 32'h0);
		off_in <= 1'b0;
		repeat (5) @(posedge clk);
		rd(OFS_STAT, 32'h0, 32'h100);
		diag_fail <= 1'b1;
		@(posedge clk);
		diag_fail <= 1'b0;
		repeat (3) @(posedge clk);
		rd(OFS_STAT, 32'h300, 32'h300);
		rd(OFS_IRQ_ST, 32'hD, 32'hF);
		wr(OFS_CTRL, 32'h11);
		repeat (300) @(posedge clk);
		cmp(32'h0, drive.torque_en);
		rst <= 1'b1;
		brake_fitted <= 1'b0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd(OFS_STAT, 32'h0, 32'h300);
		// both ways at once is no run; a drive without brake moves at once
		wr(OFS_CTRL, 32'h13);
		rd(OFS_STAT, 32'h0, 32'h40);
		wr(OFS_CTRL, 32'h11);
		run_to(1'b0, st);
		cmp(32'h0, st);
		cmp(32'h0, drive.brake_release);
		repeat (3) @(posedge clk);
		results();
	end
endmodule : tb
